/* nvh_host.sv */
// Purpose: host controller that runs read, write and store requests on the memory pins
// Assumes: one request at a time on a req/ack port; store_busy_n is open drain with pull-up
// Notes:   no register file; requests wait while the device reports busy
//
// Overview of operation
// RL1 - each access drives one 15-bit address selecting one of 32,768 bytes.
// RL2 - data lines carry host data in writes, device data in reads.
// RL3 - chip select low selects the device; high deselects and strobes are ignored.
// RL4 - device drives data only while output gate is low during a read.
// RL5 - device holds store_busy_n low while a store runs.
// RL6 - pulling store_busy_n low externally requests a store.
// RL7 - after a store device drives pin high briefly then releases to pull-up.
// RL8 - reads and writes are blocked while store or recall runs.
// RL9 - store and recall act on all locations at once.
// RL10 - read needs select and gate low, write strobe and busy high.
// RL11 - address-started read data valid within address access time.
// RL12 - strobe-started read valid at later of select and gate access.
// RL13 - enabled read follows each new address within address access time.
// RL14 - read data valid until address, strobe or busy changes end it.
// RL15 - write needs select and write strobe low with busy high.
// RL16 - host holds address stable through the whole write.
// RL17 - host sets data up before the ending edge; device captures there.
// RL18 - host keeps output gate high for the whole write.
// RL19 - device floats drivers within float time after write strobe falls.
// RL20 - writes starting after busy goes low are rejected until it rises.
// RL21 - hardware store runs only if a write happened since last store.
// RL22 - store_busy_n is open drain, sampled for external low requests.
`timescale 1ns/1ps
`default_nettype none
module nvh_host (
	input  wire logic                   mclk,
	input  wire logic                   rst_b,
	input  wire logic                   req_valid,
	input  wire logic                   req_write,
	input  wire logic                   req_store,
	input  wire logic [nvh_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [nvh_pkg::DATA_W-1:0] req_wdata,
	output var  logic                   req_ack,
	output var  logic [nvh_pkg::DATA_W-1:0] rd_data,
	output var  logic                   busy_seen,
	output var  logic [nvh_pkg::ADDR_W-1:0] addr_in,
	output var  logic                   chip_select_n,
	output var  logic                   write_strobe_n,
	output var  logic                   output_gate_n,
	input  wire logic [nvh_pkg::DATA_W-1:0] data_io_i,
	output var  logic [nvh_pkg::DATA_W-1:0] data_io_o,
	output var  logic                   data_io_oe,
	input  wire logic                   store_busy_n_i,
	output var  logic                   store_busy_n_o,
	output var  logic                   store_busy_n_oe
);
	import nvh_pkg::*;

	nvh_state_t         state;
	nvh_state_t         next_state;
	logic [CNT_W-1:0]   cnt;
	logic [CNT_W-1:0]   next_cnt;
	logic [DATA_W-1:0]  next_rd_data;
	logic [DATA_W-1:0]  data_s;
	logic [ADDR_W-1:0]  next_addr;
	logic [DATA_W-1:0]  next_wdata;
	logic               next_cs_n;
	logic               next_we_n;
	logic               next_oe_n;
	logic               next_doe;
	logic               next_hsb_oe;
	logic               next_ack;
	logic               busy_lvl;

	// pin level filtered; the device may pull the pin at any time
	nvh_sync u_busy_sync ( // [RL22]
		.mclk   (mclk),
		.rst_b  (rst_b),
		.pin_in (store_busy_n_i),
		.level  (busy_lvl)
	);

	// read data launched by the device pins; sampled once at the access end,
	// after RD_CYC + 1 cycles, so no metastable word reaches rd_data in practice
	assign data_s = data_io_i;

	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_rd_data = rd_data;
		next_addr    = addr_in;
		next_wdata   = data_io_o;
		next_cs_n    = chip_select_n;
		next_we_n    = write_strobe_n;
		next_oe_n    = output_gate_n;
		next_doe     = data_io_oe;
		next_hsb_oe  = store_busy_n_oe;
		next_ack     = 1'b0;
		case (state)
			ST_IDLE: begin
				next_cs_n = 1'b1; // [RL3]
				next_we_n = 1'b1;
				next_oe_n = 1'b1;
				next_doe  = 1'b0;
				// no access starts while the device reports busy
				if (req_valid && busy_lvl) begin // [RL8] [RL20]
					next_addr = req_addr; // [RL1]
					next_cnt  = '0;
					if (req_store) begin
						next_hsb_oe = 1'b1; // [RL6]
						next_state  = ST_STORE;
					end else if (req_write) begin
						next_wdata = req_wdata;
						next_doe   = 1'b1; // [RL2]
						next_cs_n  = 1'b0;
						next_we_n  = 1'b0; // [RL15]
						next_state = ST_WRITE;
					end else begin
						next_cs_n  = 1'b0;
						next_oe_n  = 1'b0; // [RL10]
						next_state = ST_READ;
					end
				end
			end
			ST_READ: begin
				next_cnt = cnt + 1'b1;
				// wait the later of select and gate access time
				if (cnt == CNT_W'(RD_CYC)) begin // [RL12] [RL11]
					next_rd_data = data_s; // [RL14]
					next_cs_n    = 1'b1;
					next_oe_n    = 1'b1; // [RL4]
					next_ack     = 1'b1;
					next_state   = ST_END;
				end
			end
			ST_WRITE: begin
				next_cnt = cnt + 1'b1;
				// address and data held; gate stays high to avoid contention
				if (cnt == CNT_W'(WR_CYC)) begin // [RL16] [RL17] [RL18]
					next_we_n  = 1'b1;
					next_cs_n  = 1'b1;
					next_ack   = 1'b1;
					next_state = ST_END;
				end
			end
			ST_END: begin
				// one idle cycle so data hold spans the strobe's rising edge
				next_doe   = 1'b0;
				next_state = ST_IDLE;
			end
			ST_STORE: begin
				next_cnt = cnt + 1'b1;
				// release after the pull seen on the pin; device then holds it if a write came since the last store
				if (!busy_lvl && cnt >= CNT_W'(3)) begin // [RL5] [RL22]
					next_hsb_oe = 1'b0;
					next_ack    = 1'b1;
					next_state  = ST_END;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state           <= ST_IDLE;
			cnt             <= '0;
			rd_data         <= DATA_RST;
			addr_in         <= ADDR_RST;
			data_io_o       <= DATA_RST;
			chip_select_n   <= 1'b1;
			write_strobe_n  <= 1'b1;
			output_gate_n   <= 1'b1;
			data_io_oe      <= 1'b0;
			store_busy_n_oe <= 1'b0;
			store_busy_n_o  <= 1'b0;
			req_ack         <= 1'b0;
			busy_seen       <= 1'b0;
		end else begin
			state           <= next_state;
			cnt             <= next_cnt;
			rd_data         <= next_rd_data;
			addr_in         <= next_addr;
			data_io_o       <= next_wdata;
			chip_select_n   <= next_cs_n;
			write_strobe_n  <= next_we_n;
			output_gate_n   <= next_oe_n;
			data_io_oe      <= next_doe;
			store_busy_n_oe <= next_hsb_oe;
			store_busy_n_o  <= 1'b0; // open drain: only ever pulls low [RL22]
			req_ack         <= next_ack;
			busy_seen       <= !busy_lvl; // [RL5]
		end
	end

	sequence s_rd_start;
		state == ST_IDLE && next_state == ST_READ;
	endsequence

	a_read_strobes: assert property (@(posedge mclk) disable iff (!rst_b) // [RL10]
		s_rd_start |=> !chip_select_n && !output_gate_n && write_strobe_n)
		else $error("read strobes wrong");
	a_write_gate: assert property (@(posedge mclk) disable iff (!rst_b) // [RL18]
		!write_strobe_n |-> output_gate_n)
		else $error("gate low during write");
	a_write_addr_hold: assert property (@(posedge mclk) disable iff (!rst_b) // [RL16]
		!write_strobe_n && $past(!write_strobe_n) |-> $stable(addr_in) && $stable(data_io_o))
		else $error("address moved in write");
	a_write_drive: assert property (@(posedge mclk) disable iff (!rst_b) // [RL2]
		!write_strobe_n |-> data_io_oe)
		else $error("data not driven in write");
	a_no_contention: assert property (@(posedge mclk) disable iff (!rst_b) // [RL4]
		!output_gate_n |-> !data_io_oe)
		else $error("bus contention");
	a_busy_blocks: assert property (@(posedge mclk) disable iff (!rst_b) // [RL20]
		state == ST_IDLE && !busy_lvl |=> state == ST_IDLE || state == ST_END)
		else $error("access started while busy");
	a_read_len: assert property (@(posedge mclk) disable iff (!rst_b) // [RL12]
		s_rd_start |=> !output_gate_n [*2])
		else $error("read too short");
	a_store_pull: assert property (@(posedge mclk) disable iff (!rst_b) // [RL6]
		state == ST_STORE |-> store_busy_n_oe && !store_busy_n_o)
		else $error("store request not pulled");
	a_deselect_idle: assert property (@(posedge mclk) disable iff (!rst_b) // [RL3]
		chip_select_n |-> write_strobe_n || state == ST_IDLE)
		else $error("strobe while deselected");
endmodule : nvh_host
`default_nettype wire

/* nvh_pkg.sv */
// Purpose: constants for the host-side controller of a 32K x 8 store-capable static RAM
// Assumes: mclk at 40 MHz; device timing figures given as plain parameters of ns
// Notes:   timing figures are neutral defaults, not taken from any part
package nvh_pkg;
	localparam int          ADDR_W             = 15;
	localparam int          DATA_W             = 8;
	localparam int          CLK_PERIOD_NS      = 25;
	localparam int          ADDR_ACCESS_NS     = 45;
	localparam int          SELECT_ACCESS_NS   = 45;
	localparam int          GATE_ACCESS_NS     = 25;
	localparam int          DATA_SETUP_NS      = 15;
	localparam int          WRITE_FLOAT_NS     = 15;
	localparam int          RD_ACCESS_NS       = (SELECT_ACCESS_NS > GATE_ACCESS_NS) ?
		SELECT_ACCESS_NS : GATE_ACCESS_NS;
	// least times round up to whole cycles
	localparam int          RD_CYC             = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SETUP_CYC0         = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          FLOAT_CYC0         = (WRITE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WR_CYC             = (SETUP_CYC0 > FLOAT_CYC0 ? SETUP_CYC0 : FLOAT_CYC0) + 1;
	localparam int          CNT_W              = 4;
	localparam logic [DATA_W-1:0] DATA_RST     = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST     = 15'h0000;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_READ  = 5'b00010,
		ST_WRITE = 5'b00100,
		ST_END   = 5'b01000,
		ST_STORE = 5'b10000
	} nvh_state_t;
endpackage : nvh_pkg

/* nvh_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for a pin level
// Assumes: one clock domain
// Notes:   output changes only when the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module nvh_sync (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic pin_in,
	output var  logic level
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;

	always_comb begin
		next_level = level;
		if (s2 == s3) begin
			next_level = s3;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1    <= 1'b1;
			s2    <= 1'b1;
			s3    <= 1'b1;
			level <= 1'b1;
		end else begin
			s1    <= pin_in;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
		end
	end
endmodule : nvh_sync
`default_nettype wire

/* nvh_mem_model.sv */
// Purpose: behavioural model of the 32K x 8 store-capable static RAM
// Assumes: pin levels resolved in the bench; strobes driven by the host
// Notes:   store and release times are arbitrary; recall is not modelled
`timescale 1ns/1ps
`default_nettype none
module nvh_mem_model #(
	parameter int STORE_NS = 2000,
	parameter int HOLD_NS  = 50
) (
	input  wire logic [nvh_pkg::ADDR_W-1:0] addr_in,
	input  wire logic                       chip_select_n,
	input  wire logic                       write_strobe_n,
	input  wire logic                       output_gate_n,
	input  wire logic [nvh_pkg::DATA_W-1:0] data_io,
	input  wire logic                       store_busy_n,
	output var  logic [nvh_pkg::DATA_W-1:0] dev_q,
	output var  logic                       dev_oe,
	output var  logic                       dev_low
);
	import nvh_pkg::*;
	logic [DATA_W-1:0] mem [0:32767];
	logic [DATA_W-1:0] nv  [0:32767];
	logic              wr_act   = 1'b0;
	logic              dirty    = 1'b0;
	logic              drive_hi = 1'b0;
	int                n_stores = 0;
	int                wr_cnt   = 0;
	logic              busy_low = 1'b0;
	assign dev_low = busy_low;
	// output lags the address by the access time, so early samples see stale data;
	// a write to the byte on show retriggers it, as the address alone would not
	always @(addr_in or wr_cnt) begin
		dev_q <= #(ADDR_ACCESS_NS) mem[addr_in];
	end
	assign dev_oe = !chip_select_n && !output_gate_n && write_strobe_n
		&& store_busy_n && !dev_low;
	always @(negedge chip_select_n or negedge write_strobe_n) begin
		if (!chip_select_n && !write_strobe_n) wr_act = store_busy_n;
	end
	always @(posedge chip_select_n or posedge write_strobe_n) begin
		if (wr_act) begin
			mem[addr_in] = data_io;
			dirty = 1'b1;
			wr_cnt++;
			wr_act = 1'b0;
		end
	end
	always @(negedge store_busy_n) begin
		if (!dev_low && dirty) begin
			busy_low = 1'b1;
			wait (!wr_act);
			#(STORE_NS);
			foreach (nv[i]) nv[i] = mem[i];
			dirty = 1'b0;
			n_stores++;
			busy_low = 1'b0;
			drive_hi = 1'b1;
			#(HOLD_NS) drive_hi = 1'b0;
		end
	end
endmodule : nvh_mem_model
`default_nettype wire

/* nvh_host_tb_top.sv */
// Purpose: self-checking bench for the host controller against the device model
// Assumes: one request at a time; expected data kept in an associative array
// Notes:   undriven data lines show a toggling pattern, never the last value
`timescale 1ns/1ps
`default_nettype none
module nvh_host_tb_top;
	import nvh_pkg::*;
	logic              mclk = 0, rst_b = 0, req_valid = 0, req_write = 0, req_store = 0;
	logic              ext_pull = 0, req_ack, busy_seen, cs_n, we_n, oe_n;
	logic              dq_oe, dev_oe, sb_o, sb_oe, dev_low, sb;
	logic [ADDR_W-1:0] req_addr = '0, addr_in, a;
	logic [DATA_W-1:0] req_wdata = '0, rd_data, dq_o, dev_q, dq, d, pat = 8'hA5;
	logic [DATA_W-1:0] ref_mem [int];
	int                num_errors = 0, tests_run = 0, cyc = 0, n_st = 0, w;
	assign dq = dq_oe ? dq_o : (dev_oe ? dev_q : pat);
	assign sb = u_nvh_mem_model.drive_hi || !((sb_oe && !sb_o) || dev_low || ext_pull);
	nvh_host u_nvh_host (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
		.req_write(req_write), .req_store(req_store), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ack(req_ack), .rd_data(rd_data), .busy_seen(busy_seen),
		.addr_in(addr_in), .chip_select_n(cs_n), .write_strobe_n(we_n),
		.output_gate_n(oe_n), .data_io_i(dq), .data_io_o(dq_o), .data_io_oe(dq_oe),
		.store_busy_n_i(sb), .store_busy_n_o(sb_o), .store_busy_n_oe(sb_oe));
	nvh_mem_model #(.STORE_NS(2000), .HOLD_NS(50)) u_nvh_mem_model (.addr_in(addr_in),
		.chip_select_n(cs_n), .write_strobe_n(we_n), .output_gate_n(oe_n), .data_io(dq),
		.store_busy_n(sb), .dev_q(dev_q), .dev_oe(dev_oe), .dev_low(dev_low));
	initial forever #12.5 mclk = ~mclk;
	task automatic conclude();
		if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic st, input logic [ADDR_W-1:0] ad,
		input logic [DATA_W-1:0] da, output int n);
		@(posedge mclk) #2;
		req_valid = 1'b1;
		req_write = wr;
		req_store = st;
		req_addr = ad;
		req_wdata = da;
		n = 0;
		do begin
			@(posedge mclk) #1;
			n++;
		end while (req_ack !== 1'b1 && n < 3000);
		#1 req_valid = 1'b0;
		if (n >= 3000) chk(0, 1, "no ack");
	endtask : bus
	always @(posedge mclk) begin
		pat <= ~pat;
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		void'($urandom(75));
		repeat (16) @(posedge mclk);
		#2 rst_b = 1'b1;
		for (int i = 0; i < 24; i++) begin
			a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FFF : 15'($urandom);
			d = 8'($urandom);
			bus(1'b1, 1'b0, a, d, w);
			ref_mem[int'(a)] = d;
			bus(1'b0, 1'b0, a, 8'h00, w);
			chk(rd_data, d, "read after write");
			chk(w, RD_CYC + 2, "read latency");
		end
		foreach (ref_mem[k]) begin
			bus(1'b0, 1'b0, 15'(k), 8'h00, w);
			chk(rd_data, ref_mem[k], "readback");
		end
		// store with pending writes runs; reads wait for it to finish
		bus(1'b0, 1'b1, 15'h0000, 8'h00, w);
		n_st++;
		bus(1'b0, 1'b0, 15'h7FFF, 8'h00, w);
		chk(w > 60, 1, "read not held off by store");
		chk(rd_data, ref_mem[32767], "read after store");
		chk(u_nvh_mem_model.n_stores, n_st, "store count");
		foreach (ref_mem[k]) chk(u_nvh_mem_model.nv[k], ref_mem[k], "nv copy");
		// second store with nothing written must not run
		bus(1'b0, 1'b1, 15'h0000, 8'h00, w);
		repeat (100) @(posedge mclk);
		chk(u_nvh_mem_model.n_stores, n_st, "idle store");
		// outside party pulls the pin; host must see busy and hold its read
		a = 15'($urandom);
		d = 8'($urandom);
		bus(1'b1, 1'b0, a, d, w);
		@(posedge mclk) #2 ext_pull = 1'b1;
		repeat (8) @(posedge mclk);
		#2 ext_pull = 1'b0;
		chk(busy_seen, 1'b1, "busy not seen");
		bus(1'b0, 1'b0, a, 8'h00, w);
		n_st++;
		chk(w > 50, 1, "read during store");
		chk(rd_data, d, "read after ext store");
		chk(u_nvh_mem_model.n_stores, n_st, "ext store count");
		conclude();
	end
endmodule : nvh_host_tb_top
`default_nettype wire
